//--- src/pfmux_regs.vh
`ifndef PFMUX_REGS_VH
`define PFMUX_REGS_VH

// register byte addresses
`define PFMUX_ADDR_SELECT 32'hE002C000
`define PFMUX_ADDR_LEVEL  32'hE002C020

// reset values
`define PFMUX_SELECT_RESET 32'h00000000
`define PFMUX_LEVEL_RESET  16'h0000

// selector field layout: pin n owns bits 2n+1..2n
`define PFMUX_FIELD_WIDTH 2
`define PFMUX_PIN_COUNT   16

// selector codes
`define PFMUX_FN_GPIO 2'h0
`define PFMUX_FN_ALT1 2'h1
`define PFMUX_FN_ALT2 2'h2
`define PFMUX_FN_ALT3 2'h3

// pins on which code 3 is defined (pins 1, 3, 7 and 9)
`define PFMUX_ALT3_VALID 16'h028A

`endif

//--- src/pfmux_apb_regs.v
`timescale 1ns/1ns
`include "pfmux_regs.vh"

// apb slave holding the selector word and a read-only pin level word
module pfmux_apb_regs (
  input  wire        clk,
  input  wire        reset_n,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [31:0] paddr,
  input  wire [31:0] pwdata,
  input  wire [15:0] level,
  output reg  [31:0] prdata,
  output reg         pready,
  output reg         pslverr,
  output reg  [31:0] select
);

  wire hit_select;
  wire hit_level;
  wire access;
  wire done;

  // address decode on the full byte address
  assign hit_select = (paddr == `PFMUX_ADDR_SELECT);
  assign hit_level  = (paddr == `PFMUX_ADDR_LEVEL);
  assign access     = psel & penable;
  // one wait state keeps the read path registered
  assign done       = access & pready;

  // answer one cycle into the access phase, then drop
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h00000000;
    end else begin
      pready  <= access & ~pready;
      pslverr <= access & ~pready & ~hit_select & ~(hit_level & ~pwrite);
      if (access & ~pready & ~pwrite) begin
        if (hit_select) begin
          prdata <= select;
        end else if (hit_level) begin
          prdata <= {16'h0000, level};
        end else begin
          prdata <= 32'h00000000;
        end
      end else begin
        prdata <= 32'h00000000;
      end
    end
  end

  // the write lands only at the edge that completes the transfer
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      select <= `PFMUX_SELECT_RESET;
    end else if (done & pwrite & hit_select) begin
      select <= pwdata;
    end
  end

endmodule // pfmux_apb_regs

//--- src/pfmux_top.v
`timescale 1ns/1ns
`include "pfmux_regs.vh"

// Behaviour
// - sixteen two-bit fields, field n drives pin n
// - all fields reset to zero, meaning gpio
// - gpio direction counts only under gpio code
// - peripheral code takes direction from the peripheral
// - pins 0,1: uart0, pwm_output_1/pwm_output_3, ext interrupt 0
// - pins 2,3: i2c, timer0 capture/match, ext interrupt 1
// - pins 4-7: spi0, timer0, pwm_output_2, ext interrupt 2
// - pins 8,9: uart1, pwm_output_4/pwm_output_6, ext interrupt 3
// - pins 10-15: uart1 modem, timer1, ext interrupts
// - selector word readable and writable as 32 bits
module pfmux_top (
  input  wire        CLK,
  input  wire        RESET_N,
  input  wire        PSEL,
  input  wire        PENABLE,
  input  wire        PWRITE,
  input  wire [31:0] PADDR,
  input  wire [31:0] PWDATA,
  output wire [31:0] PRDATA,
  output wire        PREADY,
  output wire        PSLVERR,
  input  wire [15:0] PIN_IN,
  output reg  [15:0] PIN_OUT,
  output reg  [15:0] PIN_OE,
  input  wire [15:0] GPIO_OUT,
  input  wire [15:0] GPIO_DIRECTION_SETTING,
  output reg  [15:0] GPIO_IN,
  input  wire        UART0_TXD,
  output reg         UART0_RXD,
  input  wire        UART1_TXD,
  input  wire        UART1_RTS_N,
  input  wire        UART1_DTR_N,
  output reg         UART1_RXD,
  output reg         UART1_CTS_N,
  output reg         UART1_DSR_N,
  output reg         UART1_DCD_N,
  output reg         UART1_RI_N,
  input  wire        I2C_SCL_OUT,
  input  wire        I2C_SCL_OE,
  output reg         I2C_SCL_IN,
  input  wire        I2C_SDA_OUT,
  input  wire        I2C_SDA_OE,
  output reg         I2C_SDA_IN,
  input  wire        SPI0_SCK_OUT,
  input  wire        SPI0_SCK_OE,
  output reg         SPI0_SCK_IN,
  input  wire        SPI0_MISO_OUT,
  input  wire        SPI0_MISO_OE,
  output reg         SPI0_MISO_IN,
  input  wire        SPI0_MOSI_OUT,
  input  wire        SPI0_MOSI_OE,
  output reg         SPI0_MOSI_IN,
  input  wire        SPI0_SSEL_OUT,
  input  wire        SPI0_SSEL_OE,
  output reg         SPI0_SSEL_N_IN,
  input  wire        PWM_OUTPUT_1,
  input  wire        PWM_OUTPUT_2,
  input  wire        PWM_OUTPUT_3,
  input  wire        PWM_OUTPUT_4,
  input  wire        PWM_OUTPUT_6,
  input  wire        TIMER0_MATCH_0,
  input  wire        TIMER0_MATCH_1,
  output reg         TIMER0_CAPTURE_0,
  output reg         TIMER0_CAPTURE_1,
  output reg         TIMER0_CAPTURE_2,
  input  wire        TIMER1_MATCH_0,
  input  wire        TIMER1_MATCH_1,
  output reg         TIMER1_CAPTURE_0,
  output reg         TIMER1_CAPTURE_1,
  output reg         EXT_INTERRUPT_0,
  output reg         EXT_INTERRUPT_1,
  output reg         EXT_INTERRUPT_2,
  output reg         EXT_INTERRUPT_3
);

  wire [31:0] select;
  wire [15:0] alt1_out;
  wire [15:0] alt1_oe;
  wire [15:0] alt2_out;
  wire [15:0] alt2_oe;
  wire [15:0] alt3_valid;
  reg  [31:0] eff_sel;
  reg  [15:0] next_pin_out;
  reg  [15:0] next_pin_oe;
  reg  [1:0]  code;
  integer     i;

  // register file on the apb bus
  pfmux_apb_regs u_regs (
    .clk     (CLK),
    .reset_n (RESET_N),
    .psel    (PSEL),
    .penable (PENABLE),
    .pwrite  (PWRITE),
    .paddr   (PADDR),
    .pwdata  (PWDATA),
    .level   (GPIO_IN),
    .prdata  (PRDATA),
    .pready  (PREADY),
    .pslverr (PSLVERR),
    .select  (select)
  );

  // a reserved code folds to gpio so the pin never floats undefined
  function [1:0] fold_code;
    input [1:0] raw;
    input       alt3_ok;
    begin
      if ((raw == `PFMUX_FN_ALT3) && !alt3_ok) begin
        fold_code = `PFMUX_FN_GPIO;
      end else begin
        fold_code = raw;
      end
    end
  endfunction

  // true when pin holds the given effective code
  function picked;
    input [31:0] sel;
    input [3:0]  pin;
    input [1:0]  fn;
    begin
      picked = (sel[{pin, 1'b0} +: 2] == fn);
    end
  endfunction

  // code 1 sources, pin 15 down to pin 0; inputs carry zero
  assign alt1_out = {2'b00, UART1_DTR_N, 2'b00, UART1_RTS_N, 1'b0,
                     UART1_TXD, SPI0_SSEL_OUT, SPI0_MOSI_OUT,
                     SPI0_MISO_OUT, SPI0_SCK_OUT, I2C_SDA_OUT,
                     I2C_SCL_OUT, 1'b0, UART0_TXD};
  assign alt1_oe  = {2'b00, 1'b1, 2'b00, 1'b1, 1'b0, 1'b1,
                     SPI0_SSEL_OE, SPI0_MOSI_OE, SPI0_MISO_OE,
                     SPI0_SCK_OE, I2C_SDA_OE, I2C_SCL_OE,
                     1'b0, 1'b1};

  // code 2 sources; captures and interrupts are inputs
  assign alt2_out = {2'b00, TIMER1_MATCH_1, TIMER1_MATCH_0, 2'b00,
                     PWM_OUTPUT_6, PWM_OUTPUT_4, PWM_OUTPUT_2, 1'b0,
                     TIMER0_MATCH_1, 1'b0, TIMER0_MATCH_0, 1'b0,
                     PWM_OUTPUT_3, PWM_OUTPUT_1};
  assign alt2_oe  = 16'h33AB;

  // pins whose code 3 is a real function; elsewhere it folds to gpio
  assign alt3_valid = `PFMUX_ALT3_VALID;

  // per-pin mux; code 3 functions are all inputs, so no drive
  always @* begin
    eff_sel      = 32'h00000000;
    next_pin_out = 16'h0000;
    next_pin_oe  = 16'h0000;
    code         = `PFMUX_FN_GPIO;
    for (i = 0; i < `PFMUX_PIN_COUNT; i = i + 1) begin
      code = fold_code(select[2*i +: 2], alt3_valid[i]);
      eff_sel[2*i +: 2] = code;
      case (code)
        `PFMUX_FN_GPIO: begin
          next_pin_out[i] = GPIO_OUT[i];
          next_pin_oe[i]  = GPIO_DIRECTION_SETTING[i];
        end
        `PFMUX_FN_ALT1: begin
          next_pin_out[i] = alt1_out[i];
          next_pin_oe[i]  = alt1_oe[i];
        end
        `PFMUX_FN_ALT2: begin
          next_pin_out[i] = alt2_out[i];
          next_pin_oe[i]  = alt2_oe[i];
        end
        default: begin
          next_pin_out[i] = 1'b0;
          next_pin_oe[i]  = 1'b0;
        end
      endcase
    end
  end

  // pin drive and gpio readback; level is seen whatever the code
  always @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      PIN_OUT <= 16'h0000;
      PIN_OE  <= 16'h0000;
      GPIO_IN <= `PFMUX_LEVEL_RESET;
    end else begin
      PIN_OUT <= next_pin_out;
      PIN_OE  <= next_pin_oe;
      GPIO_IN <= PIN_IN;
    end
  end

  // serial inputs; an unrouted line reads its idle level
  always @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      UART0_RXD      <= 1'b1;
      UART1_RXD      <= 1'b1;
      UART1_CTS_N    <= 1'b1;
      UART1_DSR_N    <= 1'b1;
      UART1_DCD_N    <= 1'b1;
      UART1_RI_N     <= 1'b1;
      I2C_SCL_IN     <= 1'b1;
      I2C_SDA_IN     <= 1'b1;
      SPI0_SCK_IN    <= 1'b0;
      SPI0_MISO_IN   <= 1'b0;
      SPI0_MOSI_IN   <= 1'b0;
      SPI0_SSEL_N_IN <= 1'b1;
    end else begin
      UART0_RXD <= picked(eff_sel, 4'd1, `PFMUX_FN_ALT1)
                   ? PIN_IN[1] : 1'b1;
      I2C_SCL_IN <= picked(eff_sel, 4'd2, `PFMUX_FN_ALT1)
                    ? PIN_IN[2] : 1'b1;
      I2C_SDA_IN <= picked(eff_sel, 4'd3, `PFMUX_FN_ALT1)
                    ? PIN_IN[3] : 1'b1;
      SPI0_SCK_IN <= picked(eff_sel, 4'd4, `PFMUX_FN_ALT1)
                     & PIN_IN[4];
      SPI0_MISO_IN <= picked(eff_sel, 4'd5, `PFMUX_FN_ALT1)
                      & PIN_IN[5];
      SPI0_MOSI_IN <= picked(eff_sel, 4'd6, `PFMUX_FN_ALT1)
                      & PIN_IN[6];
      SPI0_SSEL_N_IN <= picked(eff_sel, 4'd7, `PFMUX_FN_ALT1)
                        ? PIN_IN[7] : 1'b1;
      UART1_RXD <= picked(eff_sel, 4'd9, `PFMUX_FN_ALT1)
                   ? PIN_IN[9] : 1'b1;
      UART1_CTS_N <= picked(eff_sel, 4'd11, `PFMUX_FN_ALT1)
                     ? PIN_IN[11] : 1'b1;
      UART1_DSR_N <= picked(eff_sel, 4'd12, `PFMUX_FN_ALT1)
                     ? PIN_IN[12] : 1'b1;
      UART1_DCD_N <= picked(eff_sel, 4'd14, `PFMUX_FN_ALT1)
                     ? PIN_IN[14] : 1'b1;
      UART1_RI_N <= picked(eff_sel, 4'd15, `PFMUX_FN_ALT1)
                    ? PIN_IN[15] : 1'b1;
    end
  end

  // capture and interrupt inputs; two pins feeding one line are ored
  always @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      TIMER0_CAPTURE_0 <= 1'b0;
      TIMER0_CAPTURE_1 <= 1'b0;
      TIMER0_CAPTURE_2 <= 1'b0;
      TIMER1_CAPTURE_0 <= 1'b0;
      TIMER1_CAPTURE_1 <= 1'b0;
      EXT_INTERRUPT_0  <= 1'b0;
      EXT_INTERRUPT_1  <= 1'b0;
      EXT_INTERRUPT_2  <= 1'b0;
      EXT_INTERRUPT_3  <= 1'b0;
    end else begin
      TIMER0_CAPTURE_0 <= picked(eff_sel, 4'd2, `PFMUX_FN_ALT2)
                          & PIN_IN[2];
      TIMER0_CAPTURE_1 <= picked(eff_sel, 4'd4, `PFMUX_FN_ALT2)
                          & PIN_IN[4];
      TIMER0_CAPTURE_2 <= picked(eff_sel, 4'd6, `PFMUX_FN_ALT2)
                          & PIN_IN[6];
      TIMER1_CAPTURE_0 <= picked(eff_sel, 4'd10, `PFMUX_FN_ALT2)
                          & PIN_IN[10];
      TIMER1_CAPTURE_1 <= picked(eff_sel, 4'd11, `PFMUX_FN_ALT2)
                          & PIN_IN[11];
      EXT_INTERRUPT_0 <= picked(eff_sel, 4'd1, `PFMUX_FN_ALT3)
                         & PIN_IN[1];
      EXT_INTERRUPT_1 <= (picked(eff_sel, 4'd3, `PFMUX_FN_ALT3)
                          & PIN_IN[3])
                         | (picked(eff_sel, 4'd14, `PFMUX_FN_ALT2)
                          & PIN_IN[14]);
      EXT_INTERRUPT_2 <= (picked(eff_sel, 4'd7, `PFMUX_FN_ALT3)
                          & PIN_IN[7])
                         | (picked(eff_sel, 4'd15, `PFMUX_FN_ALT2)
                          & PIN_IN[15]);
      EXT_INTERRUPT_3 <= picked(eff_sel, 4'd9, `PFMUX_FN_ALT3)
                         & PIN_IN[9];
    end
  end

endmodule // pfmux_top

//--- testbench/pfmux_chk.sv
`timescale 1ns/1ns
`include "pfmux_regs.vh"
// compares mux outputs against a shadow of the selector word
module pfmux_chk (
  input wire logic        CLK,
  input wire logic        RESET_N,
  input wire logic        PSEL,
  input wire logic        PENABLE,
  input wire logic        PWRITE,
  input wire logic [31:0] PADDR,
  input wire logic [31:0] PWDATA,
  input wire logic [31:0] PRDATA,
  input wire logic        PREADY,
  input wire logic        PSLVERR,
  input wire logic [15:0] PIN_IN,
  input wire logic [15:0] PIN_OE,
  input wire logic [15:0] PIN_OUT,
  input wire logic [15:0] GPIO_DIRECTION_SETTING,
  input wire logic        UART0_TXD,
  input wire logic        UART0_RXD,
  input wire logic        SPI0_SCK_OE,
  input wire logic        TIMER0_MATCH_0,
  input wire logic        EXT_INTERRUPT_1
);
  localparam logic [15:0] ALT3 = `PFMUX_ALT3_VALID;
  logic [31:0] sel;
  logic [31:0] sel_q;
  logic [15:0] gm;
  logic        up;
  // sel_q lags one edge so it lines up with the output register
  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      sel   <= 32'h0;
      sel_q <= 32'h0;
      up    <= 1'b0;
    end else begin
      if (PSEL && PENABLE && PREADY && PWRITE && !PSLVERR &&
          PADDR == `PFMUX_ADDR_SELECT)
        sel <= PWDATA;
      sel_q <= sel;
      up    <= 1'b1;
    end
  end
  // pins still under gpio control: code 0 or an undefined code 3
  always_comb begin
    for (int n = 0; n < 16; n++) begin
      gm[n] = sel_q[2*n+:2] == 2'h0 ||
              (sel_q[2*n+:2] == 2'h3 && !ALT3[n]);
    end
  end
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RESET_N);
  sequence s_access;
    PSEL && PENABLE && !$past(PENABLE);
  endsequence
  sequence s_answer;
    !PREADY ##1 PREADY;
  endsequence
  chk_apb_wait: assert property (s_access |-> s_answer)
    else $error("apb answer late or early");
  chk_read_back: assert property (PREADY && !PWRITE &&
    PADDR == `PFMUX_ADDR_SELECT |-> PRDATA == sel && !PSLVERR)
    else $error("selector read wrong");
  chk_gpio_dir: assert property (up |->
    ((PIN_OE ^ $past(GPIO_DIRECTION_SETTING)) & gm) == 16'h0000)
    else $error("gpio direction not followed");
  chk_uart0_tx: assert property (sel_q[1:0] == 2'h1 |->
    PIN_OE[0] && PIN_OUT[0] == $past(UART0_TXD))
    else $error("uart0 transmit not routed");
  chk_uart0_rx: assert property (sel_q[3:2] == 2'h1 |->
    !PIN_OE[1] && UART0_RXD == $past(PIN_IN[1]))
    else $error("uart0 receive not routed");
  chk_spi_enable: assert property (sel_q[9:8] == 2'h1 |->
    PIN_OE[4] == $past(SPI0_SCK_OE))
    else $error("spi clock enable not routed");
  chk_timer_match: assert property (sel_q[7:6] == 2'h2 |->
    PIN_OE[3] && PIN_OUT[3] == $past(TIMER0_MATCH_0))
    else $error("timer match not routed");
  chk_ext_int1: assert property (sel_q[29:28] == 2'h2 &&
    sel_q[7:6] != 2'h3 |-> EXT_INTERRUPT_1 == $past(PIN_IN[14]))
    else $error("external interrupt not routed");
endmodule // pfmux_chk

bind pfmux_top pfmux_chk chk_u (.*);

//--- testbench/pfmux_far.sv
`timescale 1ns/1ns
// far side: pin levels and peripheral drives change every cycle, so a
// stale value never passes for a fresh one
module pfmux_far (
  input  wire logic        CLK,
  input  wire logic [31:0] rnd,
  output logic      [15:0] PIN_IN = 16'h0000,
  output logic      [24:0] perif = 25'h0000000
);
  always @(posedge CLK) begin
    PIN_IN <= rnd[31:16] ^ rnd[15:0];
    perif  <= rnd[24:0] ^ rnd[31:7];
  end
endmodule // pfmux_far

//--- testbench/testbench.sv
`timescale 1ns/1ns
`include "pfmux_regs.vh"
// apb traffic plus random pin activity; replies checked in order
module testbench;
  localparam logic [31:0] SEL = `PFMUX_ADDR_SELECT;
  logic        CLK = 1'b0;
  logic        RESET_N = 1'b0;
  logic        PSEL = 1'b0;
  logic        PENABLE = 1'b0;
  logic        PWRITE = 1'b0;
  logic [31:0] PADDR = 32'h0;
  logic [31:0] PWDATA = 32'h0;
  logic [31:0] rnd = 32'h9C35FCBE;
  logic [31:0] w;
  logic [32:0] q[$];
  logic [31:0] shadow = 32'h0;
  logic [31:0] exp_drv;
  logic [20:0] exp_in;
  logic [15:0] exp_lvl;
  logic        live = 1'b0;
  int          err_total = 0;
  int          n_compared = 0;
  wire  [15:0] GPIO_OUT = rnd[15:0];
  wire  [15:0] GPIO_DIRECTION_SETTING = rnd[27:12];
  wire  [15:0] PIN_IN, PIN_OUT, PIN_OE, GPIO_IN;
  wire  [24:0] pf;
  wire  [31:0] PRDATA;
  wire         PREADY, PSLVERR, UART0_RXD, UART1_RXD, UART1_CTS_N,
               UART1_DSR_N, UART1_DCD_N, UART1_RI_N, I2C_SCL_IN, I2C_SDA_IN,
               SPI0_SCK_IN, SPI0_MISO_IN, SPI0_MOSI_IN, SPI0_SSEL_N_IN,
               TIMER0_CAPTURE_0, TIMER0_CAPTURE_1, TIMER0_CAPTURE_2,
               TIMER1_CAPTURE_0, TIMER1_CAPTURE_1, EXT_INTERRUPT_0,
               EXT_INTERRUPT_1, EXT_INTERRUPT_2, EXT_INTERRUPT_3;
  wire  [20:0] seen_in = {UART0_RXD, UART1_RXD, UART1_CTS_N, UART1_DSR_N,
                          UART1_DCD_N, UART1_RI_N, I2C_SCL_IN, I2C_SDA_IN,
                          SPI0_SCK_IN, SPI0_MISO_IN, SPI0_MOSI_IN,
                          SPI0_SSEL_N_IN, TIMER0_CAPTURE_0, TIMER0_CAPTURE_1,
                          TIMER0_CAPTURE_2, TIMER1_CAPTURE_0,
                          TIMER1_CAPTURE_1, EXT_INTERRUPT_0, EXT_INTERRUPT_1,
                          EXT_INTERRUPT_2, EXT_INTERRUPT_3};

  always #50 CLK = ~CLK;
  pfmux_far far_u (.CLK(CLK), .rnd(rnd), .PIN_IN(PIN_IN), .perif(pf));
  pfmux_top dut_u (.*, .UART0_TXD(pf[0]), .UART1_TXD(pf[1]),
    .UART1_RTS_N(pf[2]), .UART1_DTR_N(pf[3]), .I2C_SCL_OUT(pf[4]),
    .I2C_SCL_OE(pf[5]), .I2C_SDA_OUT(pf[6]), .I2C_SDA_OE(pf[7]),
    .SPI0_SCK_OUT(pf[8]), .SPI0_SCK_OE(pf[9]), .SPI0_MISO_OUT(pf[10]),
    .SPI0_MISO_OE(pf[11]), .SPI0_MOSI_OUT(pf[12]), .SPI0_MOSI_OE(pf[13]),
    .SPI0_SSEL_OUT(pf[14]), .SPI0_SSEL_OE(pf[15]), .PWM_OUTPUT_1(pf[16]),
    .PWM_OUTPUT_2(pf[17]), .PWM_OUTPUT_3(pf[18]), .PWM_OUTPUT_4(pf[19]),
    .PWM_OUTPUT_6(pf[20]), .TIMER0_MATCH_0(pf[21]),
    .TIMER0_MATCH_1(pf[22]), .TIMER1_MATCH_0(pf[23]),
    .TIMER1_MATCH_1(pf[24]));

  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction
  // code 3 kept only where the pin defines it, else dropped to 2
  function automatic logic [31:0] legal(input logic [31:0] x);
    logic [15:0] ok;
    ok = `PFMUX_ALT3_VALID;
    for (int n = 0; n < 16; n++) begin
      if (x[2*n+:2] == 2'h3 && !ok[n]) x[2*n] = 1'b0;
    end
    return x;
  endfunction
  // rule model of the pin drive: {enable, value}; code 3 is input only
  function automatic logic [31:0] drive(input logic [31:0] s,
      input logic [15:0] go, input logic [15:0] gd, input logic [24:0] f);
    logic [15:0] o1, e1, o2, e2, ok, oe, out;
    ok = `PFMUX_ALT3_VALID;
    o1 = {2'h0, f[3], 2'h0, f[2], 1'b0, f[1], f[14], f[12], f[10], f[8],
          f[6], f[4], 1'b0, f[0]};
    e1 = {2'h0, 1'b1, 2'h0, 1'b1, 1'b0, 1'b1, f[15], f[13], f[11], f[9],
          f[7], f[5], 1'b0, 1'b1};
    o2 = {2'h0, f[24], f[23], 2'h0, f[20], f[19], f[17], 1'b0, f[22],
          1'b0, f[21], 1'b0, f[18], f[16]};
    e2 = 16'h33AB; // outputs on pins 0,1,3,5,7,8,9,12,13
    for (int n = 0; n < 16; n++) begin
      oe[n]  = gd[n];
      out[n] = go[n];
      if (s[2*n+:2] == 2'h1) begin
        oe[n]  = e1[n];
        out[n] = o1[n];
      end else if (s[2*n+:2] == 2'h2) begin
        oe[n]  = e2[n];
        out[n] = o2[n];
      end else if (s[2*n+:2] == 2'h3 && ok[n]) begin
        oe[n]  = 1'b0;
        out[n] = 1'b0;
      end
    end
    return {oe, out};
  endfunction
  // rule model of the lines fed from the pins, in the order of seen_in
  function automatic logic [20:0] listen(input logic [31:0] s,
                                         input logic [15:0] p);
    logic [15:0] u, a, b, c;
    for (int n = 0; n < 16; n++) begin
      u[n] = p[n] | (s[2*n+:2] != 2'h1);
      a[n] = p[n] & (s[2*n+:2] == 2'h1);
      b[n] = p[n] & (s[2*n+:2] == 2'h2);
      c[n] = p[n] & (s[2*n+:2] == 2'h3);
    end
    return {u[1], u[9], u[11], u[12], u[14], u[15], u[2], u[3], a[4], a[5],
            a[6], u[7], b[2], b[4], b[6], b[10], b[11], c[1], c[3] | b[14],
            c[7] | b[15], c[9]};
  endfunction
  task automatic check(input logic [32:0] seen, input logic [32:0] exp);
    n_compared++;
    if (seen !== exp) begin
      err_total++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic results;
    $display("compared %0d, mismatched %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  // one transfer; the note {error, data} is queued at the setup edge,
  // where a level read also learns the pin word that it will return
  task automatic apb(input logic [31:0] a, input logic [31:0] d,
                     input logic wr, input logic [32:0] e);
    int n;
    PSEL <= 1'b1;
    PWRITE <= wr;
    PADDR <= a;
    PWDATA <= d;
    @(posedge CLK);
    if (!wr && a == `PFMUX_ADDR_LEVEL) begin
      e = {17'h0, PIN_IN};
    end
    q.push_back(e);
    PENABLE <= 1'b1;
    n = 0;
    do begin
      @(posedge CLK);
      n++;
    end while (PREADY !== 1'b1 && n < 20);
    if (PREADY !== 1'b1) begin
      err_total++;
      results();
    end else begin
      PENABLE <= 1'b0;
      if (wr && a == SEL) begin
        shadow <= d;
      end
    end
  endtask
  task automatic idle(input int c);
    PSEL <= 1'b0;
    repeat (c) @(posedge CLK);
  endtask

  // fresh random pin traffic every cycle
  always @(posedge CLK) rnd <= lfsr(rnd);
  // replies come in request order, so the oldest note is the match
  always @(posedge CLK) begin
    if (PREADY === 1'b1) check({PSLVERR, PRDATA}, q.pop_front());
  end
  // pins and peripheral lines follow the selector one clock late; the
  // edges in and right after reset are skipped, outputs sit idle there
  always @(posedge CLK) begin
    if (live && RESET_N) begin
      check({1'b0, PIN_OE, PIN_OUT}, {1'b0, exp_drv});
      check({12'h0, seen_in}, {12'h0, exp_in});
      check({17'h0, GPIO_IN}, {17'h0, exp_lvl});
    end
    live    <= RESET_N;
    exp_drv <= drive(shadow, GPIO_OUT, GPIO_DIRECTION_SETTING, pf);
    exp_in  <= listen(shadow, PIN_IN);
    exp_lvl <= PIN_IN;
  end

  initial begin
    repeat (16) @(posedge CLK);
    RESET_N <= 1'b1;
    apb(SEL, 32'h0, 1'b0, 33'h0);
    apb(SEL + 32'h4, 32'h0, 1'b0, {1'b1, 32'h0});
    apb(`PFMUX_ADDR_LEVEL, 32'hFFFFFFFF, 1'b1, {1'b1, 32'h0});
    apb(`PFMUX_ADDR_LEVEL, 32'h0, 1'b0, 33'h0);
    idle(1);
    $display("reset and refusal test done");
    // every code on every pin; code 3 is reserved on most pins
    for (int k = 0; k < 4; k++) begin
      w = {16{k[1:0]}};
      apb(SEL, w, 1'b1, 33'h0);
      idle(8);
      apb(SEL, 32'h0, 1'b0, {1'b0, w});
      idle(1);
    end
    $display("all codes test done");
    // random legal words, read back straight after the write
    repeat (24) begin
      w = legal(rnd);
      apb(SEL, w, 1'b1, 33'h0);
      apb(SEL, 32'h0, 1'b0, {1'b0, w});
      idle(6);
    end
    $display("random selector test done");
    RESET_N <= 1'b0;
    shadow  <= 32'h0;
    repeat (3) @(posedge CLK);
    RESET_N <= 1'b1;
    apb(SEL, 32'h0, 1'b0, 33'h0);
    idle(2);
    $display("mid-run reset test done");
    results();
  end
endmodule // testbench
